// [src/dpm_cfg.svh]
// Purpose: constants for the dual-port ram port controller
// Assumes: 10 MHz reference clock, 11-bit address, 8-bit data
// Notes: times in ns, cycle counts derived from them
`ifndef DPM_CFG_SVH
`define DPM_CFG_SVH

`define DPM_CLK_PERIOD_NS 100
`define DPM_ADDR_W 11
`define DPM_DATA_W 8
// mailbox locations
`define DPM_LEFT_BOX_ADDR 11'h7fe
`define DPM_RIGHT_BOX_ADDR 11'h7ff
// arbitration setup between the two ports, least time
`define DPM_ARB_SETUP_NS 5
`define DPM_ARB_SETUP_CYC \
    ((`DPM_ARB_SETUP_NS + `DPM_CLK_PERIOD_NS - 1) / `DPM_CLK_PERIOD_NS)
// address and select settle before the read or write strobe (contention settle)
`define DPM_SETTLE_NS 30
`define DPM_SETTLE_CYC \
    ((`DPM_SETTLE_NS + `DPM_CLK_PERIOD_NS - 1) / `DPM_CLK_PERIOD_NS)
// write pulse width, least time
`define DPM_WRITE_PULSE_NS 40
`define DPM_WRITE_PULSE_CYC \
    ((`DPM_WRITE_PULSE_NS + `DPM_CLK_PERIOD_NS - 1) / `DPM_CLK_PERIOD_NS)
// read access, least wait before sampling
`define DPM_READ_ACCESS_NS 55
`define DPM_READ_ACCESS_CYC \
    ((`DPM_READ_ACCESS_NS + `DPM_CLK_PERIOD_NS - 1) / `DPM_CLK_PERIOD_NS)
`define DPM_CNT_W 4

`endif

// [src/dpm_pkg.sv]
// Purpose: types for the dual-port ram port controller
// Assumes: constants come from dpm_cfg.svh
// Notes: none
package dpm_pkg;
    typedef enum logic [2:0] {
        DPM_IDLE,
        DPM_SETTLE,
        DPM_STROBE,
        DPM_RECOVER,
        DPM_DONE
    } dpm_state_e;

    typedef logic [3:0] dpm_cnt_t;
endpackage

// [src/dpm_port_seq.sv]
// Purpose: one port sequencer, drives a single ram port's pins
// Assumes: inputs synchronous to i_ref_clk
// Notes: a contention-refused access is retried until it passes
`include "dpm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dpm_port_seq #(
    parameter int ADDR_W = `DPM_ADDR_W,
    parameter int DATA_W = `DPM_DATA_W
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic i_clear_box,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_contention_n,
    input wire logic [DATA_W-1:0] i_data_in,
    output logic o_ready,
    output logic o_done,
    output logic o_retry,
    output logic [DATA_W-1:0] o_rdata,
    output logic [ADDR_W-1:0] o_addr,
    output logic o_select_n,
    output logic o_read_write_n,
    output logic o_output_enable_n,
    output logic [DATA_W-1:0] o_data_out,
    output logic o_data_oe_n
);
    typedef struct packed {
        dpm_pkg::dpm_state_e st;
        dpm_pkg::dpm_cnt_t cnt;
        logic we;
        logic clr;
        logic done;
        logic retry;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
    } dpm_seq_s;

    dpm_seq_s s_q;
    dpm_seq_s s_d;

    function automatic dpm_pkg::dpm_cnt_t dpm_cyc(input int n);
        dpm_cyc = (n < 1) ? dpm_pkg::dpm_cnt_t'(1) : dpm_pkg::dpm_cnt_t'(n);
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.retry = 1'b0;
        case (s_q.st)
            dpm_pkg::DPM_IDLE: begin
                if (i_req) begin
                    s_d.we = i_we;
                    s_d.clr = i_clear_box;
                    s_d.addr = i_addr;
                    s_d.wdata = i_wdata;
                    s_d.cnt = dpm_cyc(`DPM_SETTLE_CYC);
                    s_d.st = dpm_pkg::DPM_SETTLE;
                end
            end
            // address and select held before any strobe
            dpm_pkg::DPM_SETTLE: begin
                if (s_q.cnt > dpm_pkg::dpm_cnt_t'(1)) begin
                    s_d.cnt = s_q.cnt - dpm_pkg::dpm_cnt_t'(1);
                end else if (!i_contention_n) begin
                    // stall while the far side owns the cell
                    s_d.retry = 1'b1;
                end else begin
                    s_d.cnt = s_q.we ? dpm_cyc(`DPM_WRITE_PULSE_CYC)
                                     : dpm_cyc(`DPM_READ_ACCESS_CYC);
                    s_d.st = dpm_pkg::DPM_STROBE;
                end
            end
            dpm_pkg::DPM_STROBE: begin
                if (!i_contention_n) begin
                    // access was refused by the device, redo it, read or write
                    s_d.retry = 1'b1;
                    // re-present the address after the setup gap
                    s_d.cnt = dpm_cyc(`DPM_ARB_SETUP_CYC);
                    s_d.st = dpm_pkg::DPM_SETTLE;
                end else if (s_q.cnt > dpm_pkg::dpm_cnt_t'(1)) begin
                    s_d.cnt = s_q.cnt - dpm_pkg::dpm_cnt_t'(1);
                end else begin
                    if (!s_q.we) begin
                        s_d.rdata = i_data_in;
                    end
                    s_d.st = dpm_pkg::DPM_RECOVER;
                end
            end
            dpm_pkg::DPM_RECOVER: begin
                s_d.st = dpm_pkg::DPM_DONE;
            end
            default: begin
                s_d.done = 1'b1;
                s_d.st = dpm_pkg::DPM_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    wire logic active;
    wire logic strobe;
    assign active = (s_q.st == dpm_pkg::DPM_SETTLE) ||
                    (s_q.st == dpm_pkg::DPM_STROBE);
    assign strobe = (s_q.st == dpm_pkg::DPM_STROBE);

    assign o_ready = (s_q.st == dpm_pkg::DPM_IDLE);
    assign o_done = s_q.done;
    assign o_retry = s_q.retry;
    assign o_rdata = s_q.rdata;
    assign o_addr = s_q.addr;
    // deselected outside an access
    assign o_select_n = ~active;
    // write only while select and direction both low
    assign o_read_write_n = ~(strobe & s_q.we);
    // output enable low on reads, and on a mailbox clear access
    assign o_output_enable_n = ~(active & (~s_q.we | s_q.clr));
    assign o_data_out = s_q.wdata;
    assign o_data_oe_n = ~(active & s_q.we);
endmodule

`default_nettype wire

// [src/dpm_host.sv]
// Purpose: host controller driving both ports of a dual-port ram
// Assumes: one clock; the ram and its pins are outside this module
// Notes: no bus slave; commands come on plain request ports
`include "dpm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dpm_host #(
    parameter int ADDR_W = `DPM_ADDR_W,
    parameter int DATA_W = `DPM_DATA_W,
    parameter int BANKS = 1
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // ------------------------------------------------------------
    // left user side
    // ------------------------------------------------------------
    input wire logic i_left_req,
    input wire logic i_left_we,
    input wire logic [ADDR_W-1:0] i_left_addr,
    input wire logic [DATA_W-1:0] i_left_wdata,
    output logic o_left_ready,
    output logic o_left_done,
    output logic [DATA_W-1:0] o_left_rdata,
    output logic o_left_mail,
    // ------------------------------------------------------------
    // right user side
    // ------------------------------------------------------------
    input wire logic i_right_req,
    input wire logic i_right_we,
    input wire logic [ADDR_W-1:0] i_right_addr,
    input wire logic [DATA_W-1:0] i_right_wdata,
    output logic o_right_ready,
    output logic o_right_done,
    output logic [DATA_W-1:0] o_right_rdata,
    output logic o_right_mail,
    output logic o_contention_err,
    // ------------------------------------------------------------
    // ram pins, left port
    // ------------------------------------------------------------
    output logic [ADDR_W-1:0] o_left_port_address_bits,
    output logic o_left_select_n,
    output logic o_left_read_write_n,
    output logic o_left_output_enable_n,
    output logic [DATA_W-1:0] o_left_port_data_bits,
    output logic o_left_port_data_bits_oe_n,
    input wire logic [DATA_W-1:0] i_left_port_data_bits,
    input wire logic [BANKS-1:0] i_left_contention_n,
    input wire logic i_left_mailbox_flag_n,
    // ------------------------------------------------------------
    // ram pins, right port
    // ------------------------------------------------------------
    output logic [ADDR_W-1:0] o_right_port_address_bits,
    output logic o_right_select_n,
    output logic o_right_read_write_n,
    output logic o_right_output_enable_n,
    output logic [DATA_W-1:0] o_right_port_data_bits,
    output logic o_right_port_data_bits_oe_n,
    input wire logic [DATA_W-1:0] i_right_port_data_bits,
    input wire logic [BANKS-1:0] i_right_contention_n,
    input wire logic i_right_mailbox_flag_n
);
    // ------------------------------------------------------------
    // contention and mailbox state
    // ------------------------------------------------------------
    typedef struct packed {
        logic err;
        logic lmail;
        logic rmail;
    } dpm_host_s;

    dpm_host_s h_q;
    dpm_host_s h_d;

    logic left_cont_n;
    logic right_cont_n;
    logic left_retry;
    logic right_retry;

    // one master's contention drives every slave alike
    // banks in depth: any low bank means contention
    assign left_cont_n = &i_left_contention_n;
    assign right_cont_n = &i_right_contention_n;

    // a read of its own box clears the flag in the ram
    function automatic logic dpm_is_box(input logic [ADDR_W-1:0] a,
                                        input logic [ADDR_W-1:0] box);
        dpm_is_box = (a == box);
    endfunction

    always_comb begin
        h_d = h_q;
        // contention seen is reported as an error event
        h_d.err = left_retry | right_retry;
        // flags are active low and level
        h_d.lmail = ~i_left_mailbox_flag_n;
        h_d.rmail = ~i_right_mailbox_flag_n;
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            h_q <= '0;
        end else begin
            h_q <= h_d;
        end
    end

    assign o_contention_err = h_q.err;
    // users may leave the mail outputs unread
    assign o_left_mail = h_q.lmail;
    assign o_right_mail = h_q.rmail;

    // ------------------------------------------------------------
    // port sequencers
    // ------------------------------------------------------------
    dpm_port_seq #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_left (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_req(i_left_req),
        .i_we(i_left_we),
        .i_clear_box(dpm_is_box(i_left_addr, ADDR_W'(`DPM_LEFT_BOX_ADDR))),
        .i_addr(i_left_addr),
        .i_wdata(i_left_wdata),
        .i_contention_n(left_cont_n),
        .i_data_in(i_left_port_data_bits),
        .o_ready(o_left_ready),
        .o_done(o_left_done),
        .o_retry(left_retry),
        .o_rdata(o_left_rdata),
        .o_addr(o_left_port_address_bits),
        .o_select_n(o_left_select_n),
        .o_read_write_n(o_left_read_write_n),
        .o_output_enable_n(o_left_output_enable_n),
        .o_data_out(o_left_port_data_bits),
        .o_data_oe_n(o_left_port_data_bits_oe_n)
    );

    dpm_port_seq #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_right (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_req(i_right_req),
        .i_we(i_right_we),
        .i_clear_box(dpm_is_box(i_right_addr, ADDR_W'(`DPM_RIGHT_BOX_ADDR))),
        .i_addr(i_right_addr),
        .i_wdata(i_right_wdata),
        .i_contention_n(right_cont_n),
        .i_data_in(i_right_port_data_bits),
        .o_ready(o_right_ready),
        .o_done(o_right_done),
        .o_retry(right_retry),
        .o_rdata(o_right_rdata),
        .o_addr(o_right_port_address_bits),
        .o_select_n(o_right_select_n),
        .o_read_write_n(o_right_read_write_n),
        .o_output_enable_n(o_right_output_enable_n),
        .o_data_out(o_right_port_data_bits),
        .o_data_oe_n(o_right_port_data_bits_oe_n)
    );
endmodule

`default_nettype wire

// [tb/dpm_host_props.sv]
// Purpose: concurrent checks on the dpm_host ports
// Assumes: one clock, reset asynchronous and active high
// Notes: the two sides are alike, so some checks watch one side
`timescale 1ns/1ps
`include "dpm_cfg.svh"
`default_nettype none
module dpm_host_chk #(
    parameter int ADDR_W = 11,
    parameter int BANKS = 1
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_left_req,
    input wire logic o_left_ready,
    input wire logic o_left_done,
    input wire logic o_left_select_n,
    input wire logic o_left_read_write_n,
    input wire logic o_left_output_enable_n,
    input wire logic [ADDR_W-1:0] o_left_port_address_bits,
    input wire logic [BANKS-1:0] i_left_contention_n,
    input wire logic i_left_mailbox_flag_n,
    input wire logic o_left_mail,
    input wire logic o_right_select_n,
    input wire logic o_right_read_write_n,
    input wire logic o_right_output_enable_n,
    input wire logic [ADDR_W-1:0] o_right_port_address_bits,
    input wire logic [BANKS-1:0] i_right_contention_n,
    input wire logic i_right_mailbox_flag_n,
    input wire logic o_right_mail
);
    // ----------------
    // access checks
    // ----------------
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);
    sequence s_taken;
        i_left_req && o_left_ready;
    endsequence
    sequence s_free;
        &i_left_contention_n;
    endsequence
    // done is registered on leaving the done state, five edges after taking
    AST_DONE_LAT: assert property (s_taken ##1 s_free [*4] |=> o_left_done)
        else $error("left done not five cycles after request");
    AST_DONE_ONE: assert property (o_left_done |=> !o_left_done)
        else $error("left done longer than one cycle");
    AST_STROBE_SEL: assert property (!o_left_read_write_n |-> !o_left_select_n)
        else $error("left strobe without select");
    AST_STROBE_ONE: assert property ($fell(o_left_read_write_n) |=> $rose(o_left_read_write_n))
        else $error("left strobe not one cycle");
    AST_BUSY_HOLD: assert property (!(&i_right_contention_n) |=> o_right_read_write_n)
        else $error("right strobe under contention");
    AST_RCLR: assert property (!o_right_select_n && o_right_port_address_bits == `DPM_RIGHT_BOX_ADDR |-> !o_right_output_enable_n)
        else $error("right box access without output enable");
    AST_LCLR: assert property (!o_left_select_n && o_left_port_address_bits == `DPM_LEFT_BOX_ADDR |-> !o_left_output_enable_n)
        else $error("left box access without output enable");
    AST_LMAIL: assert property (!i_left_mailbox_flag_n |=> o_left_mail)
        else $error("left mail not following flag");
    AST_RMAIL: assert property (i_right_mailbox_flag_n |=> !o_right_mail)
        else $error("right mail not clearing");
endmodule
bind dpm_host dpm_host_chk #(.ADDR_W(ADDR_W), .BANKS(BANKS)) chk_u (
    .i_ref_clk, .i_sys_rst, .i_left_req, .o_left_ready, .o_left_done,
    .o_left_select_n, .o_left_read_write_n, .o_left_output_enable_n,
    .o_left_port_address_bits, .i_left_contention_n, .i_left_mailbox_flag_n,
    .o_left_mail, .o_right_select_n, .o_right_read_write_n,
    .o_right_output_enable_n, .o_right_port_address_bits,
    .i_right_contention_n, .i_right_mailbox_flag_n, .o_right_mail
);
`default_nettype wire

// [tb/dpm_ram_model.sv]
// Purpose: behavioural dual-port ram with mailboxes and arbitration
// Assumes: index 0 is the left port, 1 the right
// Notes: equal arrival times go to the left port
`timescale 1ns/1ps
`default_nettype none
module dpm_ram_model (
    input wire logic [10:0] i_addr [2],
    input wire logic i_sel_n [2],
    input wire logic i_rw_n [2],
    input wire logic i_oe_n [2],
    input wire logic [7:0] i_bus [2],
    output logic [7:0] o_rd [2],
    output logic o_busy_n [2],
    output logic o_flag_n [2]
);
    logic [7:0] mem [2048];
    logic [7:0] last [2] = '{8'h00, 8'h00};
    logic flag_n [2] = '{1'b1, 1'b1};
    realtime t [2] = '{0.0, 0.0};
    wire match = !i_sel_n[0] && !i_sel_n[1] && i_addr[0] == i_addr[1];
    wire lwin = t[0] <= t[1];
    assign o_busy_n[0] = !(match && !lwin);
    assign o_busy_n[1] = !(match && lwin);
    assign o_flag_n = flag_n;
    for (genvar p = 0; p < 2; p++) begin : g_port
        localparam logic [10:0] PEER_BOX = p ? 11'h7fe : 11'h7ff;
        localparam logic [10:0] OWN_BOX = p ? 11'h7ff : 11'h7fe;
        wire rd_on = !i_sel_n[p] && i_rw_n[p] && !i_oe_n[p];
        wire wr_on = !i_sel_n[p] && !i_rw_n[p] && o_busy_n[p];
        wire clr_on = !i_sel_n[p] && !i_oe_n[p] && o_busy_n[p];
        always @(i_sel_n[p] or i_addr[p]) t[p] = $realtime;
        always @* if (wr_on) mem[i_addr[p]] = i_bus[p];
        always @* if (rd_on) last[p] = mem[i_addr[p]];
        // released bus shows the inverse, never a stale copy
        assign o_rd[p] = rd_on ? mem[i_addr[p]] : ~last[p];
        always @* begin
            if (wr_on && i_addr[p] == PEER_BOX) flag_n[1-p] = 1'b0;
            if (clr_on && i_addr[p] == OWN_BOX) flag_n[p] = 1'b1;
        end
    end
endmodule
`default_nettype wire

// [tb/dpm_host_tb_top.sv]
// Purpose: self-checking bench for dpm_host against a ram model
// Assumes: 10 MHz clock, inputs change 1 ns after the rising edge
// Notes: index 0 is the left port, 1 the right
`timescale 1ns/1ps
`default_nettype none
module dpm_host_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req [2] = '{1'b0, 1'b0};
    logic we [2] = '{1'b0, 1'b0};
    logic [10:0] ad [2] = '{11'h000, 11'h000};
    logic [7:0] wd [2] = '{8'h00, 8'h00};
    logic rdy [2], dn [2], ml [2], sl [2], rw [2], oe [2], hoe [2];
    logic bsy [2], flg [2], cerr;
    logic [10:0] pa [2];
    logic [7:0] rq [2], hd [2], rd [2], bus [2], q0, q1;
    int err_total = 0;
    int num_checks = 0;
    int errs = 0;
    always #50 clk = ~clk;
    always @(posedge clk) if (cerr === 1'b1) errs <= errs + 1;
    assign bus[0] = !hoe[0] ? hd[0] : rd[0];
    assign bus[1] = !hoe[1] ? hd[1] : rd[1];
    dpm_host dut_u (
        .i_ref_clk(clk), .i_sys_rst(rst), .o_contention_err(cerr),
        .i_left_req(req[0]), .i_left_we(we[0]), .i_left_addr(ad[0]),
        .i_left_wdata(wd[0]), .o_left_ready(rdy[0]), .o_left_done(dn[0]),
        .o_left_rdata(rq[0]), .o_left_mail(ml[0]),
        .i_right_req(req[1]), .i_right_we(we[1]), .i_right_addr(ad[1]),
        .i_right_wdata(wd[1]), .o_right_ready(rdy[1]), .o_right_done(dn[1]),
        .o_right_rdata(rq[1]), .o_right_mail(ml[1]),
        .o_left_port_address_bits(pa[0]), .o_left_select_n(sl[0]),
        .o_left_read_write_n(rw[0]), .o_left_output_enable_n(oe[0]),
        .o_left_port_data_bits(hd[0]), .o_left_port_data_bits_oe_n(hoe[0]),
        .i_left_port_data_bits(bus[0]), .i_left_contention_n(bsy[0]),
        .i_left_mailbox_flag_n(flg[0]),
        .o_right_port_address_bits(pa[1]), .o_right_select_n(sl[1]),
        .o_right_read_write_n(rw[1]), .o_right_output_enable_n(oe[1]),
        .o_right_port_data_bits(hd[1]), .o_right_port_data_bits_oe_n(hoe[1]),
        .i_right_port_data_bits(bus[1]), .i_right_contention_n(bsy[1]),
        .i_right_mailbox_flag_n(flg[1])
    );
    dpm_ram_model ram_u (
        .i_addr(pa), .i_sel_n(sl), .i_rw_n(rw), .i_oe_n(oe), .i_bus(bus),
        .o_rd(rd), .o_busy_n(bsy), .o_flag_n(flg)
    );
    // ----------------
    // helpers
    // ----------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // one access; entered and left 1 ns after a rising edge
    task automatic acc(input int p, input logic w, input logic [10:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        req[p] = 1'b1;
        we[p] = w;
        ad[p] = a;
        wd[p] = d;
        while (rdy[p] !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        req[p] = 1'b0;
        while (dn[p] !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 60) begin
            err_total++;
            give_verdict();
        end
        q = rq[p];
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic sc_plain();
        chk(sl[0], 1'b1);
        chk(hoe[1], 1'b1);
        acc(0, 1'b1, 11'h123, 8'ha5, q0);
        acc(1, 1'b0, 11'h123, 8'h00, q1);
        chk(q1, 8'ha5);
        acc(1, 1'b1, 11'h000, 8'h3c, q1);
        acc(0, 1'b0, 11'h000, 8'h00, q0);
        chk(q0, 8'h3c);
    endtask
    task automatic sc_mail();
        acc(0, 1'b1, 11'h7ff, 8'h5e, q0);
        step();
        chk(ml[1], 1'b1);
        chk(ml[0], 1'b0);
        acc(1, 1'b0, 11'h7ff, 8'h00, q1);
        chk(q1, 8'h5e);
        step();
        chk(ml[1], 1'b0);
        acc(1, 1'b1, 11'h7fe, 8'hc3, q1);
        step();
        chk(ml[0], 1'b1);
        acc(0, 1'b1, 11'h7fe, 8'h99, q0);
        step();
        chk(ml[0], 1'b0);
        acc(0, 1'b0, 11'h7fe, 8'h00, q0);
        chk(q0, 8'h99);
    endtask
    task automatic sc_contend();
        errs = 0;
        fork
            acc(0, 1'b1, 11'h010, 8'h01, q0);
            acc(1, 1'b1, 11'h011, 8'h02, q1);
        join
        chk(errs, 0);
        acc(0, 1'b1, 11'h2aa, 8'h33, q0);
        fork
            acc(0, 1'b0, 11'h2aa, 8'h00, q0);
            acc(1, 1'b1, 11'h2aa, 8'h44, q1);
        join
        chk(q0, 8'h33);
        chk(errs != 0, 1'b1);
        acc(0, 1'b0, 11'h2aa, 8'h00, q0);
        chk(q0, 8'h44);
        acc(1, 1'b0, 11'h011, 8'h00, q1);
        chk(q1, 8'h02);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        sc_plain();
        sc_mail();
        sc_contend();
        give_verdict();
    end
endmodule
`default_nettype wire
